// ==== qdac_params.svh ====
// Constants for the quad converter update control: addresses, fields, resets, counts
`ifndef QDAC_PARAMS_SVH
`define QDAC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Address byte
// ----------------------------------------------------------------------------
`define QD_ADDR_FIXED      5'h13
`define QD_ADDR_BCAST      7'h48
`define QD_DIR_WRITE       1'h0

// ----------------------------------------------------------------------------
// Control byte field positions
// ----------------------------------------------------------------------------
`define QD_CTL_ZERO_HI     7
`define QD_CTL_ZERO_LO     6
`define QD_CTL_MODE_HI     5
`define QD_CTL_MODE_LO     4
`define QD_CTL_BC_DATA     2
`define QD_CTL_SEL_HI      2
`define QD_CTL_SEL_LO      1
`define QD_CTL_PD          0

// ----------------------------------------------------------------------------
// Data and power-down layout
// ----------------------------------------------------------------------------
`define QD_PD_CODE_HI      7
`define QD_PD_CODE_LO      6
`define QD_LOW_DATA_HI     7
`define QD_LOW_DATA_LO     4
`define QD_CODE_NORMAL     2'h0

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define QD_WORD_RESET      14'h0000
`define QD_BYTE_RESET      8'h00
`define QD_BITS_PER_BYTE   4'h8

`endif

// ==== qdac_pkg.sv ====
// Types shared by the quad converter update control
package qdac_pkg;

   // -------------------------------------------------------------------------
   // Transfer state, Gray coded along address, control, high, low
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {
      QD_ST_IDLE   = 3'h0,
      QD_ST_ADDR   = 3'h1,
      QD_ST_CTRL   = 3'h3,
      QD_ST_HIGH   = 3'h2,
      QD_ST_LOW    = 3'h6,
      QD_ST_IGNORE = 3'h7
   } qd_state_t;

   // -------------------------------------------------------------------------
   // Update mode field
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      QD_MODE_STORE    = 2'h0,
      QD_MODE_LOAD_ONE = 2'h1,
      QD_MODE_LOAD_ALL = 2'h2,
      QD_MODE_BCAST    = 2'h3
   } qd_mode_t;

   typedef logic [13:0] qd_word_t;

endpackage : qdac_pkg

// ==== qdac_rx_if.sv ====
// Byte-level link between the serial receiver and the update control
`timescale 1ns/1ps
interface qdac_rx_if;
   logic       start_p;
   logic       stop_p;
   logic       byte_p;
   logic [7:0] byte_v;
   logic       ack_want;
   logic       ack_done_p;
   logic       sda_oe_n;

   modport rx  (output start_p, stop_p, byte_p, byte_v, ack_done_p, sda_oe_n,
                input  ack_want);
   modport ctl (input  start_p, stop_p, byte_p, byte_v, ack_done_p, sda_oe_n,
                output ack_want);
endinterface : qdac_rx_if

// ==== qdac_bus_rx.sv ====
// Two-wire serial receiver: pin sync, start/stop, byte shift, acknowledge drive
`timescale 1ns/1ps
`include "qdac_params.svh"
module qdac_bus_rx (
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   qdac_rx_if.rx     link
);

   // -------------------------------------------------------------------------
   // Pin synchronisers and edge detect
   // -------------------------------------------------------------------------
   logic       scl_s1_r, scl_s2_r, scl_d_r;
   logic       sda_s1_r, sda_s2_r, sda_d_r;
   logic [7:0] shift_r;
   logic [3:0] bit_cnt_r;
   logic       ack_ph_r;
   logic       scl_rise, scl_fall, start_c, stop_c;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         scl_s1_r <= 1'h1;
         scl_s2_r <= 1'h1;
         scl_d_r  <= 1'h1;
         sda_s1_r <= 1'h1;
         sda_s2_r <= 1'h1;
         sda_d_r  <= 1'h1;
      end else begin
         scl_s1_r <= scl_i;
         scl_s2_r <= scl_s1_r;
         scl_d_r  <= scl_s2_r;
         sda_s1_r <= sda_i;
         sda_s2_r <= sda_s1_r;
         sda_d_r  <= sda_s2_r;
      end
   end

   assign scl_rise = scl_s2_r & ~scl_d_r;
   assign scl_fall = ~scl_s2_r & scl_d_r;
   // Both lines sampled with equal delay, so a data move under a high clock is a condition
   assign start_c  = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   assign stop_c   = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

   // -------------------------------------------------------------------------
   // Bit counter, shifter and acknowledge slot
   // -------------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         shift_r         <= `QD_BYTE_RESET;
         bit_cnt_r       <= 4'h0;
         ack_ph_r        <= 1'h0;
         link.byte_p     <= 1'h0;
         link.ack_done_p <= 1'h0;
         link.sda_oe_n   <= 1'h1;
         link.start_p    <= 1'h0;
         link.stop_p     <= 1'h0;
      end else begin
         link.byte_p     <= 1'h0;
         link.ack_done_p <= 1'h0;
         link.start_p    <= start_c;
         link.stop_p     <= stop_c;
         if (start_c || stop_c) begin
            bit_cnt_r     <= 4'h0;
            ack_ph_r      <= 1'h0;
            link.sda_oe_n <= 1'h1;
         end else if (scl_rise && bit_cnt_r < `QD_BITS_PER_BYTE) begin
            shift_r   <= {shift_r[6:0], sda_s2_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == `QD_BITS_PER_BYTE - 4'h1) begin
               link.byte_p <= 1'h1;
            end
         end else if (scl_fall && bit_cnt_r == `QD_BITS_PER_BYTE) begin
            if (!ack_ph_r) begin
               // Pull data low through the whole ninth clock high time
               ack_ph_r      <= 1'h1;
               link.sda_oe_n <= ~link.ack_want;
            end else begin
               ack_ph_r        <= 1'h0;
               bit_cnt_r       <= 4'h0;
               link.sda_oe_n   <= 1'h1;
               link.ack_done_p <= ~link.sda_oe_n;
            end
         end
      end
   end

   assign link.byte_v = shift_r;

endmodule : qdac_bus_rx

// ==== qdac_ctrl.sv ====
// Quad 12-bit converter update control behind a two-wire serial slave
`timescale 1ns/1ps
`include "qdac_params.svh"
module qdac_ctrl #(
   parameter int DATA_W   = 12,
   parameter int CHANNELS = 4
) (
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n_o,
   input  wire logic        addr_select_hi_i,
   input  wire logic        addr_select_lo_i,
   input  wire logic        async_load_input_i,
   output logic [13:0]      conv_channel_a_o,
   output logic [13:0]      conv_channel_b_o,
   output logic [13:0]      conv_channel_c_o,
   output logic [13:0]      conv_channel_d_o
);

   // -------------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------------
   if (DATA_W != 12) begin : g_bad_width
      $error("qdac_ctrl serves 12-bit data only");
   end
   if (CHANNELS != 4) begin : g_bad_chan
      $error("qdac_ctrl serves four channels only");
   end

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   qdac_rx_if link ();

   qdac_pkg::qd_state_t state_r;
   qdac_pkg::qd_word_t  temp_r [CHANNELS];
   qdac_pkg::qd_word_t  conv_r [CHANNELS];
   qdac_pkg::qd_word_t  new_word;
   qdac_pkg::qd_mode_t  mode;
   logic [7:0]          control_byte_store_r;
   logic [7:0]          high_byte_store_r;
   logic [7:0]          low_byte_store_r;
   logic                pend_r;
   logic                ack_want_r;
   logic                sda_r;
   logic [1:0]          pin_s1_r, pin_s2_r, addr_pins_r, pin_wait_r;
   logic                addr_cap_r;
   logic                ld_s1_r, ld_s2_r, ld_d_r;
   logic                ld_edge, commit, addr_match, powerdown_flag;
   logic [1:0]          channel_pick;

   // -------------------------------------------------------------------------
   // Helper functions
   // -------------------------------------------------------------------------
   // Replace the power-down code, keep the 12 data bits
   function automatic qdac_pkg::qd_word_t set_code(input qdac_pkg::qd_word_t w,
                                                    input logic [1:0] code);
      set_code = {code, w[11:0]};
   endfunction : set_code

   function automatic qdac_pkg::qd_word_t data_word(input logic [7:0] hi,
                                                     input logic [7:0] lo);
      data_word = {`QD_CODE_NORMAL, hi, lo[`QD_LOW_DATA_HI:`QD_LOW_DATA_LO]};
   endfunction : data_word

   // -------------------------------------------------------------------------
   // Serial receiver
   // -------------------------------------------------------------------------
   qdac_bus_rx u_rx (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .scl_i   (scl_i),
      .sda_i   (sda_i),
      .link    (link.rx)
   );

   assign link.ack_want = ack_want_r;
   assign sda_oe_n_o    = link.sda_oe_n;
   assign sda_o         = sda_r;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         sda_r <= 1'h0;
      end else begin
         sda_r <= 1'h0;
      end
   end

   // -------------------------------------------------------------------------
   // Address pins caught once after reset, load input synchronised
   // -------------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pin_s1_r    <= 2'h0;
         pin_s2_r    <= 2'h0;
         addr_pins_r <= 2'h0;
         addr_cap_r  <= 1'h0;
         pin_wait_r  <= 2'h0;
      end else begin
         pin_s1_r <= {addr_select_hi_i, addr_select_lo_i};
         pin_s2_r <= pin_s1_r;
         // Third cycle after release: only then does the second stage hold post-reset pins
         if (!addr_cap_r) begin
            pin_wait_r <= pin_wait_r + 2'h1;
            if (pin_wait_r == 2'h2) begin
               addr_pins_r <= pin_s2_r;
               addr_cap_r  <= 1'h1;
            end
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ld_s1_r <= 1'h0;
         ld_s2_r <= 1'h0;
         ld_d_r  <= 1'h0;
      end else begin
         ld_s1_r <= async_load_input_i;
         ld_s2_r <= ld_s1_r;
         ld_d_r  <= ld_s2_r;
      end
   end

   assign ld_edge        = ld_s2_r & ~ld_d_r;
   assign addr_match     = link.byte_v[0] == `QD_DIR_WRITE && addr_cap_r &&
                           (link.byte_v[7:1] == {`QD_ADDR_FIXED, addr_pins_r} ||
                            link.byte_v[7:1] == `QD_ADDR_BCAST);
   assign mode           = qdac_pkg::qd_mode_t'(
                           control_byte_store_r[`QD_CTL_MODE_HI:`QD_CTL_MODE_LO]);
   assign channel_pick   = control_byte_store_r[`QD_CTL_SEL_HI:`QD_CTL_SEL_LO];
   assign powerdown_flag = control_byte_store_r[`QD_CTL_PD];
   assign commit         = link.ack_done_p & pend_r;

   // -------------------------------------------------------------------------
   // Transfer sequencing
   // -------------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_r    <= qdac_pkg::QD_ST_IDLE;
         ack_want_r <= 1'h0;
      end else if (link.start_p) begin
         state_r    <= qdac_pkg::QD_ST_ADDR;
         ack_want_r <= 1'h0;
      end else if (link.stop_p) begin
         state_r    <= qdac_pkg::QD_ST_IDLE;
         ack_want_r <= 1'h0;
      end else if (link.byte_p) begin
         ack_want_r <= 1'h1;
         case (state_r)
            qdac_pkg::QD_ST_ADDR: begin
               if (addr_match) begin
                  state_r <= qdac_pkg::QD_ST_CTRL;
               end else begin
                  // Reads and foreign addresses get no acknowledge
                  state_r    <= qdac_pkg::QD_ST_IGNORE;
                  ack_want_r <= 1'h0;
               end
            end
            qdac_pkg::QD_ST_CTRL: state_r <= qdac_pkg::QD_ST_HIGH;
            qdac_pkg::QD_ST_HIGH: state_r <= qdac_pkg::QD_ST_LOW;
            qdac_pkg::QD_ST_LOW: begin
               if (powerdown_flag) begin
                  state_r <= qdac_pkg::QD_ST_IGNORE;
               end else begin
                  state_r <= qdac_pkg::QD_ST_HIGH;
               end
            end
            default: begin
               state_r    <= state_r;
               ack_want_r <= 1'h0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Byte stores
   // -------------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         control_byte_store_r <= `QD_BYTE_RESET;
         high_byte_store_r    <= `QD_BYTE_RESET;
         low_byte_store_r     <= `QD_BYTE_RESET;
      end else if (link.byte_p) begin
         if (state_r == qdac_pkg::QD_ST_CTRL) begin
            control_byte_store_r <= link.byte_v;
         end else if (state_r == qdac_pkg::QD_ST_HIGH) begin
            high_byte_store_r <= link.byte_v;
         end else if (state_r == qdac_pkg::QD_ST_LOW) begin
            low_byte_store_r <= link.byte_v;
         end
      end
   end

   // Pair is armed by the low byte and fired by its acknowledge
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pend_r <= 1'h0;
      end else if (link.start_p || link.stop_p) begin
         pend_r <= 1'h0;
      end else if (link.byte_p && state_r == qdac_pkg::QD_ST_LOW) begin
         pend_r <= 1'h1;
      end else if (link.ack_done_p) begin
         pend_r <= 1'h0;
      end
   end

   // -------------------------------------------------------------------------
   // Temporary and converter registers
   // -------------------------------------------------------------------------
   always_comb begin
      if (powerdown_flag) begin
         new_word = set_code(temp_r[channel_pick],
                             high_byte_store_r[`QD_PD_CODE_HI:`QD_PD_CODE_LO]);
      end else begin
         new_word = data_word(high_byte_store_r, low_byte_store_r);
      end
   end

   // A serial update in the same cycle as a load edge wins; the edge is lost
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < CHANNELS; i++) begin
            temp_r[i] <= `QD_WORD_RESET;
            conv_r[i] <= `QD_WORD_RESET;
         end
      end else if (commit) begin
         case (mode)
            qdac_pkg::QD_MODE_STORE: begin
               temp_r[channel_pick] <= new_word;
            end
            qdac_pkg::QD_MODE_LOAD_ONE: begin
               temp_r[channel_pick] <= new_word;
               conv_r[channel_pick] <= new_word;
            end
            qdac_pkg::QD_MODE_LOAD_ALL: begin
               temp_r[channel_pick] <= new_word;
               for (int i = 0; i < CHANNELS; i++) begin
                  conv_r[i] <= (2'(i) == channel_pick) ? new_word : temp_r[i];
               end
            end
            default: begin
               for (int i = 0; i < CHANNELS; i++) begin
                  if (!control_byte_store_r[`QD_CTL_BC_DATA]) begin
                     conv_r[i] <= temp_r[i];
                  end else if (!powerdown_flag) begin
                     temp_r[i] <= data_word(high_byte_store_r, low_byte_store_r);
                     conv_r[i] <= data_word(high_byte_store_r, low_byte_store_r);
                  end else begin
                     conv_r[i] <= set_code(conv_r[i],
                        high_byte_store_r[`QD_PD_CODE_HI:`QD_PD_CODE_LO]);
                  end
               end
            end
         endcase
      end else if (ld_edge) begin
         // Relies on software having filled the temporaries first
         for (int i = 0; i < CHANNELS; i++) begin
            conv_r[i] <= temp_r[i];
         end
      end
   end

   assign conv_channel_a_o = conv_r[0];
   assign conv_channel_b_o = conv_r[1];
   assign conv_channel_c_o = conv_r[2];
   assign conv_channel_d_o = conv_r[3];

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   sequence s_low_byte;
      state_r == qdac_pkg::QD_ST_LOW && link.byte_p;
   endsequence

   sequence s_addr_byte;
      state_r == qdac_pkg::QD_ST_ADDR && link.byte_p && !link.start_p && !link.stop_p;
   endsequence

   chk_addr_match: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      s_addr_byte and addr_match |=> state_r == qdac_pkg::QD_ST_CTRL && ack_want_r)
      else $error("matching address not accepted");

   chk_addr_miss: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      s_addr_byte and !addr_match |=> state_r == qdac_pkg::QD_ST_IGNORE && !ack_want_r)
      else $error("foreign address accepted");

   chk_ctrl_keep: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state_r != qdac_pkg::QD_ST_CTRL |=> $stable(control_byte_store_r))
      else $error("control byte changed outside control slot");

   chk_pd_two_bytes: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      s_low_byte and powerdown_flag and !link.start_p and !link.stop_p
      |=> state_r == qdac_pkg::QD_ST_IGNORE)
      else $error("power-down transfer took more than two bytes");

   chk_pair_loop: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      s_low_byte and !powerdown_flag and !link.start_p and !link.stop_p
      |=> state_r == qdac_pkg::QD_ST_HIGH)
      else $error("data pair did not loop to high byte");

   chk_arm_pair: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      s_low_byte and !link.start_p and !link.stop_p |=> pend_r)
      else $error("low byte did not arm an update");

   chk_store_only: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      commit && mode == qdac_pkg::QD_MODE_STORE |=> $stable(conv_r[0]) && $stable(conv_r[3]))
      else $error("store mode changed a converter");

   chk_load_one: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      commit && mode == qdac_pkg::QD_MODE_LOAD_ONE
      |=> conv_r[$past(channel_pick)] == temp_r[$past(channel_pick)])
      else $error("selected converter not loaded");

   chk_load_edge: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      ld_edge && !commit |=> conv_r[1] == $past(temp_r[1]) && conv_r[2] == $past(temp_r[2]))
      else $error("load edge did not copy temporaries");

   chk_abort_pair: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      link.start_p || link.stop_p |=> !pend_r ##1 !commit)
      else $error("abandoned pair still pending");

   chk_conv_cause: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $changed(conv_r[0]) |-> $past(commit) || $past(ld_edge))
      else $error("converter changed without an update event");

endmodule : qdac_ctrl

// ==== qdac_master_model.sv ====
// Two-wire bus master model: clock and open-drain data toward the device
`timescale 1ns/1ps
module qdac_master_model (
   input  wire logic clock_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   // Released lines float to the pull-up level
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : tick

   // Serves as start and repeated start; data is raised while the clock is low, then falls while it is high
   task automatic start_cond();
      tick(1);
      sda_o = 1'b1;
      tick(3);
      scl_o = 1'b1;
      tick(4);
      sda_o = 1'b0;
      tick(4);
      scl_o = 1'b0;
   endtask : start_cond

   task automatic stop_cond();
      tick(1);
      sda_o = 1'b0;
      tick(3);
      scl_o = 1'b1;
      tick(4);
      sda_o = 1'b1;
      tick(4);
   endtask : stop_cond

   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         tick(1);
         sda_o = b[i];
         tick(3);
         scl_o = 1'b1;
         tick(4);
         scl_o = 1'b0;
      end
      tick(1);
      sda_o = 1'b1;
      tick(3);
      scl_o = 1'b1;
      tick(2);
      ack = (sda_i === 1'b0);
      tick(2);
      scl_o = 1'b0;
   endtask : send_byte
endmodule : qdac_master_model

// ==== quad_dac_i2c_update_control_bench.sv ====
// Self-checking bench for the quad converter update control
`timescale 1ns/1ps
`include "qdac_params.svh"
module quad_dac_i2c_update_control_bench;
   localparam logic [7:0] ADR = {`QD_ADDR_FIXED, 2'b10, `QD_DIR_WRITE};
   localparam logic [7:0] BC  = {`QD_ADDR_BCAST, `QD_DIR_WRITE};
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ld = 1'b0;
   logic [1:0]  pins = 2'h2;
   logic        scl, m_sda, sda_d, oe_n;
   logic [13:0] conv [4];
   wire         sda_line = m_sda & (oe_n | sda_d);
   int          error_cnt = 0;
   int          check_count = 0;
   int          cyc = 0;

   always #25 clk = ~clk;

   qdac_master_model m (.clock_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_o(m_sda));
   qdac_ctrl dut (.clock_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_d), .sda_oe_n_o(oe_n), .addr_select_hi_i(pins[1]),
      .addr_select_lo_i(pins[0]), .async_load_input_i(ld),
      .conv_channel_a_o(conv[0]), .conv_channel_b_o(conv[1]),
      .conv_channel_c_o(conv[2]), .conv_channel_d_o(conv[3]));

   // --------------------------------------------------------------------------
   // Checking helpers
   // --------------------------------------------------------------------------
   task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic chk_all(input logic [13:0] e [4]);
      for (int i = 0; i < 4; i++) chk($sformatf("conv%0d", i), e[i], conv[i]);
   endtask : chk_all

   // Bytes past n_ack must be refused
   task automatic xfer(input logic [7:0] q[$], input int n_ack);
      logic a;
      m.start_cond();
      foreach (q[i]) begin
         m.send_byte(q[i], a);
         chk("ack", {13'h0, i < n_ack}, {13'h0, a});
      end
      m.stop_cond();
   endtask : xfer

   // --------------------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------------------
   task automatic s_single();
      chk_all('{14'h0, 14'h0, 14'h0, 14'h0});
      xfer('{ADR, 8'h02, 8'hab, 8'hc5}, 4);
      chk_all('{14'h0, 14'h0, 14'h0, 14'h0});
      xfer('{ADR, 8'h10, 8'h12, 8'h3f}, 4);
      chk_all('{14'h0123, 14'h0, 14'h0, 14'h0});
      xfer('{ADR, 8'h24, 8'h45, 8'h60}, 4);
      chk_all('{14'h0123, 14'h0abc, 14'h0456, 14'h0});
      xfer('{ADR, 8'h06, 8'h33, 8'h30}, 4);
      chk_all('{14'h0123, 14'h0abc, 14'h0456, 14'h0});
   endtask : s_single

   task automatic s_pairs_pd();
      xfer('{ADR, 8'h12, 8'h11, 8'h10, 8'h22, 8'h20}, 6);
      chk("conv_b", 14'h0222, conv[1]);
      xfer('{ADR, 8'h13, 8'hc0, 8'h00, 8'h55}, 4);
      chk("conv_b", 14'h3222, conv[1]);
      xfer('{ADR, 8'h10, 8'h77}, 3);
      chk("conv_a", 14'h0123, conv[0]);
   endtask : s_pairs_pd

   task automatic s_bcast();
      xfer('{BC, 8'h30, 8'h00, 8'h00}, 4);
      chk_all('{14'h0123, 14'h3222, 14'h0456, 14'h0333});
      xfer('{BC, 8'h34, 8'h77, 8'h70}, 4);
      chk_all('{14'h0777, 14'h0777, 14'h0777, 14'h0777});
      xfer('{BC, 8'h35, 8'h40, 8'h00}, 4);
      chk_all('{14'h1777, 14'h1777, 14'h1777, 14'h1777});
   endtask : s_bcast

   task automatic s_async();
      xfer('{ADR, 8'h00, 8'h5a, 8'h50}, 4);
      chk("conv_a", 14'h1777, conv[0]);
      @(posedge clk);
      #1 ld = 1'b1;
      repeat (6) @(posedge clk);
      chk_all('{14'h05a5, 14'h0777, 14'h0777, 14'h0777});
      #1 ld = 1'b0;
   endtask : s_async

   task automatic s_refuse();
      xfer('{8'h9e, 8'h10, 8'h99, 8'h90}, 0);
      xfer('{8'h9d, 8'h10, 8'h99, 8'h90}, 0);
      chk("conv_a", 14'h05a5, conv[0]);
   endtask : s_refuse

   // Pins are only taken after reset, so a new address needs a reset
   task automatic s_reset();
      @(posedge clk);
      #1 rst_n = 1'b0;
      pins = 2'h1;
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (6) @(posedge clk);
      chk_all('{14'h0, 14'h0, 14'h0, 14'h0});
      xfer('{ADR, 8'h10, 8'h12, 8'h30}, 0);
      xfer('{8'h9a, 8'h10, 8'h12, 8'h30}, 4);
      chk("conv_a", 14'h0123, conv[0]);
   endtask : s_reset

   task automatic final_report();
      if (error_cnt == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   // Whole run needs about 4800 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (6) @(posedge clk);
      s_single();
      s_pairs_pd();
      s_bcast();
      s_async();
      s_refuse();
      s_reset();
      final_report();
   end
endmodule : quad_dac_i2c_update_control_bench
